// *** verilog/spc_spi.sv ***
// Serial peripheral interface: pins, control registers and byte shifter
//
// What this block does
// - Exchange one byte in eight clock cycles
// - Clock pin driven as master, input as slave
// - Enabled block owns MOSI and clock direction
// - Slave select always an input in slave
// - Select high: MISO released, clocks ignored
// - Master select feeds fault only when enabled
// - Select pin ownership follows mode table
// - Receive enable gates receive-full request
// - Receive-full set on each received byte
// - Master bit chooses mode, resets to master
// - Polarity bit sets idle clock, resets low
// - Both ends match polarity; phase resets set
// - Phase zero slave starts on select fall
// - Phase one slave starts on first edge
// - Select high leaves state machine untouched
// - Wired-OR bit makes outputs open-drain
// - Enable bit; clearing gives partial reset
// - Transmit enable gates transmit-empty request
// - Transmit-empty set when byte enters shifter
// - Disabled: flag set, transfer aborted, cleared
// - Mode fault on slave rise or master low
`timescale 1ns/10ps
module spc_spi (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  // Master out, slave in pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  // Master in, slave out pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Slave select pin, input only
  input  wire logic        ss_n_i,
  // Pin ownership towards the shared port
  output logic             pins_owned_o,
  output logic             ss_gpio_o,
  // Interrupt requests
  output logic             rx_irq_o,
  output logic             tx_irq_o,
  output logic             err_irq_o
);

  // Registers and state
  logic [7:0]             ctrl_q;
  logic [7:0]             sts_ctl_q;
  logic [7:0]             txd_q;
  logic [7:0]             rxd_q;
  logic [7:0]             shift_q;
  logic                   rx_full_q;
  logic                   ovr_q;
  logic                   mode_fault_flag_q;
  logic                   tx_empty_q;
  logic                   ovr_arm_q;
  logic                   mode_fault_flag_arm_q;
  spc_pkg::spc_state_t    state_q;
  logic [4:0]             ec_q;
  logic [7:0]             hc_q;
  logic                   ph_q;
  logic                   out_bit_q;
  logic                   rxb_q;
  logic                   done_q;
  logic [3:0]             sync1_q;
  logic [3:0]             sync2_q;
  logic [3:0]             prev_q;
  logic [7:0]             rdata_q;

  // Decoded controls
  logic enable, master, cpol, cpha, wom, mode_fault_detect_enable;
  logic ss_s, sck_s, mosi_s, miso_s;
  logic ss_fall, ss_rise, slave_edge, slave_lead, master_edge;
  logic load_shift, in_bit, m_fault, s_fault;
  logic data_rd, data_wr, sts_rd;
  logic [7:0] ld_src, div;
  logic [1:0] sck_pin, mosi_pin, miso_pin;

  // Half period in bus cycles for a rate select
  function automatic logic [7:0] rate_div(input logic [1:0] rate);
    logic [7:0] d;
    d = spc_pkg::BAUD_DIV0;
    if (rate == 2'h1) begin
      d = spc_pkg::BAUD_DIV1;
    end else if (rate == 2'h2) begin
      d = spc_pkg::BAUD_DIV2;
    end else if (rate == 2'h3) begin
      d = spc_pkg::BAUD_DIV3;
    end
    return d;
  endfunction : rate_div

  // Pin driver: returns {enable, level}; open-drain only pulls low
  function automatic logic [1:0] pin_drive(input logic drv, input logic lvl, input logic od);
    logic [1:0] r;
    r = {drv, lvl};
    if (od) begin
      r = {drv & ~lvl, 1'b0};
    end
    return r;
  endfunction : pin_drive

  assign enable = ctrl_q[spc_pkg::CTL_ENABLE];
  assign master = ctrl_q[spc_pkg::CTL_MASTER];
  assign cpol   = ctrl_q[spc_pkg::CTL_CPOL];
  assign cpha   = ctrl_q[spc_pkg::CTL_CPHA];
  assign wom    = ctrl_q[spc_pkg::CTL_WIRED_OR];
  assign mode_fault_detect_enable = sts_ctl_q[spc_pkg::STS_MODE_FAULT_FLAG_EN];
  assign div    = rate_div(sts_ctl_q[spc_pkg::STS_RATE_HI:spc_pkg::STS_RATE_LO]);

  // Pin inputs pass two flops; bit order ss, sck, mosi, miso
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      prev_q  <= 4'hF;
    end else begin
      sync1_q <= {ss_n_i, sck_i, mosi_i, miso_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign ss_s   = sync2_q[3];
  assign sck_s  = sync2_q[2];
  assign mosi_s = sync2_q[1];
  assign miso_s = sync2_q[0];

  // Slave select reaches the block in slave mode, or master with fault detect
  assign ss_fall    = prev_q[3] & ~ss_s;
  assign ss_rise    = ~prev_q[3] & ss_s;
  // Select high masks every incoming clock edge
  assign slave_edge = enable & ~master & ~ss_s & (sck_s ^ prev_q[2]);
  assign slave_lead = slave_edge & (prev_q[2] == cpol);
  assign master_edge = (hc_q == div - 8'h01);
  assign in_bit     = master ? miso_s : mosi_s;
  assign load_shift = enable & (state_q == spc_pkg::ST_IDLE) & ~tx_empty_q;
  assign ld_src     = tx_empty_q ? shift_q : txd_q;
  // Faults only when detection is enabled; master ignores select otherwise
  assign m_fault    = enable & master & mode_fault_detect_enable & ~ss_s;
  assign s_fault    = enable & ~master & mode_fault_detect_enable & ss_rise & (state_q == spc_pkg::ST_ACTIVE);

  // Register strobes
  assign data_rd = rd_i & (addr_i == spc_pkg::ADDR_DATA);
  assign data_wr = wr_i & (addr_i == spc_pkg::ADDR_DATA);
  assign sts_rd  = rd_i & (addr_i == spc_pkg::ADDR_STATUS);

  // Control register; a master fault drops the enable bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= spc_pkg::CONTROL_RESET;
    end else if (m_fault) begin
      ctrl_q[spc_pkg::CTL_ENABLE] <= 1'b0;
    end else if (wr_i && addr_i == spc_pkg::ADDR_CONTROL) begin
      ctrl_q <= wdata_i & spc_pkg::CONTROL_MASK;
    end
  end

  // Status control bits: error enable, fault detect, rate
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sts_ctl_q <= spc_pkg::STS_CTL_RESET;
    end else if (wr_i && addr_i == spc_pkg::ADDR_STATUS) begin
      sts_ctl_q <= wdata_i & spc_pkg::STS_CTL_MASK;
    end
  end

  // Transmit buffer holds late writes until the next transfer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      txd_q <= 8'h00;
    end else if (data_wr) begin
      txd_q <= wdata_i;
    end
  end

  // Transmit-empty: set on load into shifter and while disabled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_empty_q <= 1'b1;
    end else if (!enable || load_shift) begin
      tx_empty_q <= 1'b1;
    end else if (data_wr) begin
      tx_empty_q <= 1'b0;
    end
  end

  // Receive side: overflow keeps the old byte; set wins over clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rxd_q     <= 8'h00;
      rx_full_q <= 1'b0;
      ovr_q     <= 1'b0;
      ovr_arm_q <= 1'b0;
    end else begin
      if (done_q && !rx_full_q) begin
        rxd_q <= shift_q;
      end
      if (done_q) begin
        rx_full_q <= 1'b1;
      end else if (data_rd) begin
        rx_full_q <= 1'b0;
      end
      if (done_q && rx_full_q) begin
        ovr_q <= 1'b1;
      end else if (data_rd && ovr_arm_q) begin
        ovr_q <= 1'b0;
      end
      if (sts_rd) begin
        ovr_arm_q <= ovr_q;
      end else if (data_rd) begin
        ovr_arm_q <= 1'b0;
      end
    end
  end

  // Mode fault flag: cleared by status read then data write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else begin
      if (m_fault || s_fault) begin
        mode_fault_flag_q <= 1'b1;
      end else if (data_wr && mode_fault_flag_arm_q) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (sts_rd) begin
        mode_fault_flag_arm_q <= mode_fault_flag_q;
      end else if (data_wr) begin
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // Transfer engine; disable aborts and clears it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !enable) begin
      state_q   <= spc_pkg::ST_IDLE;
      shift_q   <= 8'h00;
      ec_q      <= 5'h00;
      hc_q      <= 8'h00;
      ph_q      <= 1'b0;
      out_bit_q <= 1'b0;
      rxb_q     <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        spc_pkg::ST_IDLE: begin
          shift_q <= ld_src;
          hc_q    <= 8'h00;
          ph_q    <= 1'b0;
          ec_q    <= 5'h00;
          if (master) begin
            if (!tx_empty_q) begin
              state_q   <= spc_pkg::ST_ACTIVE;
              out_bit_q <= txd_q[7];
            end
          end else if (!cpha && ss_fall) begin
            state_q   <= spc_pkg::ST_ACTIVE;
            out_bit_q <= ld_src[7];
          end else if (cpha && slave_lead) begin
            state_q   <= spc_pkg::ST_ACTIVE;
            out_bit_q <= ld_src[7];
            ec_q      <= 5'h01;
          end
        end
        spc_pkg::ST_ACTIVE: begin
          if (master) begin
            hc_q <= master_edge ? 8'h00 : hc_q + 8'h01;
          end
          // In slave mode, select high holds everything as it is
          if ((master && master_edge) || slave_edge) begin
            ph_q <= ~ph_q;
            ec_q <= ec_q + 5'h01;
            if (!ec_q[0]) begin
              if (cpha) begin
                out_bit_q <= shift_q[7];
              end else begin
                rxb_q <= in_bit;
              end
            end else begin
              if (cpha) begin
                shift_q <= {shift_q[6:0], in_bit};
              end else begin
                shift_q   <= {shift_q[6:0], rxb_q};
                out_bit_q <= shift_q[6];
              end
              if (ec_q == spc_pkg::LAST_EDGE) begin
                state_q <= spc_pkg::ST_IDLE;
                done_q  <= 1'b1;
              end
            end
          end
        end
        default: begin
          state_q <= spc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pin levels before the output flops
  assign sck_pin  = pin_drive(enable & master, cpol ^ ph_q, wom);
  assign mosi_pin = pin_drive(enable & master, out_bit_q, wom);
  assign miso_pin = pin_drive(enable & ~master & ~ss_s, out_bit_q, wom);

  // Registered pins, ownership and requests
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sck_oe_o     <= 1'b0;
      sck_o        <= 1'b0;
      mosi_oe_o    <= 1'b0;
      mosi_o       <= 1'b0;
      miso_oe_o    <= 1'b0;
      miso_o       <= 1'b0;
      pins_owned_o <= 1'b0;
      ss_gpio_o    <= 1'b1;
      rx_irq_o     <= 1'b0;
      tx_irq_o     <= 1'b0;
      err_irq_o    <= 1'b0;
    end else begin
      {sck_oe_o, sck_o}   <= sck_pin;
      {mosi_oe_o, mosi_o} <= mosi_pin;
      {miso_oe_o, miso_o} <= miso_pin;
      pins_owned_o <= enable;
      ss_gpio_o    <= ~enable | (master & ~mode_fault_detect_enable);
      rx_irq_o     <= enable & rx_full_q & ctrl_q[spc_pkg::CTL_RX_IRQ_EN];
      tx_irq_o     <= tx_empty_q & ctrl_q[spc_pkg::CTL_TX_IRQ_EN];
      err_irq_o    <= ctrl_q[spc_pkg::CTL_RX_IRQ_EN] & sts_ctl_q[spc_pkg::STS_ERR_IRQ] & (ovr_q | mode_fault_flag_q);
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (!rd_i) begin
      rdata_q <= 8'h00;
    end else if (addr_i == spc_pkg::ADDR_CONTROL) begin
      rdata_q <= ctrl_q;
    end else if (addr_i == spc_pkg::ADDR_STATUS) begin
      rdata_q <= {rx_full_q, sts_ctl_q[6], ovr_q, mode_fault_flag_q, tx_empty_q, sts_ctl_q[2:0]};
    end else if (addr_i == spc_pkg::ADDR_DATA) begin
      rdata_q <= rxd_q;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

  // Helper: edges seen in the current transfer
  logic [4:0] edges_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state_q == spc_pkg::ST_IDLE) begin
      edges_q <= (cpha && slave_lead && !master) ? 5'h01 : 5'h00;
    end else if ((master && master_edge) || slave_edge) begin
      edges_q <= edges_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_byte_len;
    $rose(done_q) |-> $past(edges_q) == spc_pkg::LAST_EDGE;
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("byte ended after wrong edge count");

  property p_sck_dir;
    sck_oe_o |-> $past(enable) && $past(master);
  endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("clock driven while not master");

  property p_miso_z;
    (ss_s && !master) ##1 1 |-> !miso_oe_o;
  endproperty
  a_miso_z: assert property (p_miso_z) else $error("MISO driven with select high");

  property p_ss_hold;
    (state_q == spc_pkg::ST_ACTIVE && !master && ss_s && enable && !wr_i) |=>
      state_q == spc_pkg::ST_ACTIVE && $stable(ec_q) && $stable(shift_q);
  endproperty
  a_ss_hold: assert property (p_ss_hold) else $error("select high changed transfer state");

  property p_rx_full;
    done_q |=> rx_full_q ##1 (rx_full_q || $past(data_rd));
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("receive-full not set after byte");

  property p_tx_empty;
    load_shift |=> tx_empty_q && state_q != spc_pkg::ST_IDLE || !master;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("transmit-empty not set on load");

  property p_partial;
    !enable |=> tx_empty_q && state_q == spc_pkg::ST_IDLE && shift_q == 8'h00 && !pins_owned_o &&
      !sck_oe_o && !mosi_oe_o && !miso_oe_o;
  endproperty
  a_partial: assert property (p_partial) else $error("partial reset incomplete");

  property p_mfault;
    m_fault |=> mode_fault_flag_q && !enable;
  endproperty
  a_mfault: assert property (p_mfault) else $error("master mode fault not taken");

  property p_reset_val;
    $past(!rst_n_i) |-> ctrl_q == spc_pkg::CONTROL_RESET && tx_empty_q && !rx_full_q;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("wrong control reset value");

  property p_od;
    wom |=> !mosi_o && !sck_o && !miso_o;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");

  property p_gpio;
    ss_gpio_o |-> $past(!enable || (master && !mode_fault_detect_enable));
  endproperty
  a_gpio: assert property (p_gpio) else $error("select given to port while in use");

  c_master_byte: cover property (master && done_q);
  c_slave_byte:  cover property (!master && done_q);
  c_overflow:    cover property (done_q && rx_full_q);
  c_fault:       cover property ($rose(mode_fault_flag_q));

endmodule : spc_spi

// *** verilog/spc_pkg.sv ***
// Package of offsets, field positions, reset values and timing counts for the serial peripheral block
package spc_pkg;

  // Register offsets as printed
  localparam logic [15:0] ADDR_CONTROL  = 16'h0010;
  localparam logic [15:0] ADDR_STATUS   = 16'h0011;
  localparam logic [15:0] ADDR_DATA     = 16'h0012;

  // spi_control field positions
  localparam int CTL_RX_IRQ_EN = 7;
  localparam int CTL_MASTER    = 5;
  localparam int CTL_CPOL      = 4;
  localparam int CTL_CPHA      = 3;
  localparam int CTL_WIRED_OR  = 2;
  localparam int CTL_ENABLE    = 1;
  localparam int CTL_TX_IRQ_EN = 0;

  // spi_status_control field positions
  localparam int STS_RX_FULL   = 7;
  localparam int STS_ERR_IRQ   = 6;
  localparam int STS_OVERRUN   = 5;
  localparam int STS_MODE_FLT  = 4;
  localparam int STS_TX_EMPTY  = 3;
  localparam int STS_MODE_FAULT_FLAG_EN   = 2;
  localparam int STS_RATE_HI   = 1;
  localparam int STS_RATE_LO   = 0;

  // Reset values and writable masks
  localparam logic [7:0] CONTROL_RESET  = 8'h28;
  localparam logic [7:0] CONTROL_MASK   = 8'hBF;
  localparam logic [7:0] STS_CTL_RESET  = 8'h00;
  localparam logic [7:0] STS_CTL_MASK   = 8'h47;

  // Transfer length: eight serial clock cycles, two edges each
  localparam logic [4:0] LAST_EDGE      = 5'h0F;

  // Master half period in bus cycles per rate select
  localparam logic [7:0] BAUD_DIV0      = 8'h02;
  localparam logic [7:0] BAUD_DIV1      = 8'h08;
  localparam logic [7:0] BAUD_DIV2      = 8'h20;
  localparam logic [7:0] BAUD_DIV3      = 8'h80;

  // Transfer state
  typedef enum logic {ST_IDLE, ST_ACTIVE} spc_state_t;

endpackage : spc_pkg

// *** tb/spc_peer.sv ***
// Behavioural far-end partner: slave while the block masters, master while it is a slave
`timescale 1ns/10ps
module spc_peer (
  // Resolved link lines
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  // Slave side control
  input  wire logic       sl_sel_i,
  input  wire logic [7:0] sl_tx_i,
  // Drives towards the link
  output logic            sck_o,
  output logic            sck_oe_o,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  output logic            miso_o,
  output logic            miso_oe_o,
  output logic            ss_n_o,
  // Byte taken as slave
  output logic [7:0]      sl_rx_o
);
  logic [7:0] sl_sh;
  logic [3:0] sl_cnt;

  // Quiet start, clock released until first frame
  initial begin
    sck_o = 1'b0;
    sck_oe_o = 1'b0;
    mosi_o = 1'b0;
    mosi_oe_o = 1'b0;
    miso_o = 1'b0;
    ss_n_o = 1'b1;
    sl_rx_o = 8'h00;
    sl_sh = 8'h00;
    sl_cnt = 4'h0;
  end

  // Slave reloads on every select change so an aborted frame leaves no residue
  always @(sl_sel_i) begin
    sl_sh = sl_tx_i;
    sl_cnt = 4'h0;
  end

  // Released line falls to the pull-up when not selected
  assign miso_oe_o = sl_sel_i;

  // Phase one, polarity zero: drive on rising, sample on falling
  always @(posedge sck_i) if (sl_sel_i) miso_o = sl_sh[7];

  always @(negedge sck_i) if (sl_sel_i && sl_cnt < 4'h8) begin
    sl_sh = {sl_sh[6:0], mosi_i};
    sl_cnt = sl_cnt + 4'h1;
    if (sl_cnt == 4'h8) sl_rx_o = sl_sh;
  end

  // Master frame at 800 ns period, select raised after every byte
  // Gap: select lifted for four stray clocks after the first nibble
  task automatic xfer(input logic [7:0] tx, input logic cpha, input logic sel, input logic gap,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    #37;
    sck_oe_o = 1'b1;
    mosi_oe_o = 1'b1;
    ss_n_o = !sel;
    mosi_o = tx[7];
    #400;
    for (i = 7; i >= 0; i--) begin
      if (gap && i == 3) begin
        ss_n_o = 1'b1;
        repeat (8) begin
          #400;
          sck_o = ~sck_o;
        end
        #400;
        ss_n_o = 1'b0;
        #400;
      end
      if (cpha) mosi_o = tx[i];
      sck_o = 1'b1;
      if (!cpha) rx[i] = miso_i;
      #400;
      sck_o = 1'b0;
      if (cpha) rx[i] = miso_i;
      else if (i > 0) mosi_o = tx[i-1];
      #400;
    end
    ss_n_o = 1'b1;
    mosi_oe_o = 1'b0;
  endtask : xfer
endmodule : spc_peer

// *** tb/tb_spc_spi.sv ***
// Self-checking bench for the serial peripheral block against its far-end partner
`timescale 1ns/10ps
module tb_spc_spi;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ss_force_n = 1'b1;
  logic        sl_sel = 1'b0;
  logic [7:0]  sl_tx = 8'h00;
  logic        wo_chk = 1'b0;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  wire  [7:0]  rdata_o;
  wire  [7:0]  sl_rx;
  wire         sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  wire         p_sck, p_sck_oe, p_mosi, p_mosi_oe, p_miso, p_miso_oe, p_ss_n;
  wire         pins_owned_o, ss_gpio_o, rx_irq_o, tx_irq_o, err_irq_o;
  wire         sck_w, mosi_w, miso_w;

  // Pull-ups on every link line; the block wins any overlap
  assign sck_w  = sck_oe_o  ? sck_o  : (p_sck_oe  ? p_sck  : 1'b1);
  assign mosi_w = mosi_oe_o ? mosi_o : (p_mosi_oe ? p_mosi : 1'b1);
  assign miso_w = miso_oe_o ? miso_o : (p_miso_oe ? p_miso : 1'b1);

  always #50 clk_i = ~clk_i;

  spc_spi i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .ss_n_i(p_ss_n & ss_force_n), .pins_owned_o(pins_owned_o), .ss_gpio_o(ss_gpio_o),
    .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o), .err_irq_o(err_irq_o));

  spc_peer i_peer (
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sl_sel_i(sl_sel), .sl_tx_i(sl_tx),
    .sck_o(p_sck), .sck_oe_o(p_sck_oe), .mosi_o(p_mosi), .mosi_oe_o(p_mosi_oe), .miso_o(p_miso),
    .miso_oe_o(p_miso_oe), .ss_n_o(p_ss_n), .sl_rx_o(sl_rx));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // One-cycle register strobes, changed just after the edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // Open-drain clock and MOSI outputs never drive high; looked at mid-cycle where they are settled
  always @(negedge clk_i) if (wo_chk) chk({6'h00, sck_oe_o & sck_o, mosi_oe_o & mosi_o}, 8'h00);

  // Hang guard, far above the expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic t_reset;
    logic [7:0] v;
    rd(spc_pkg::ADDR_CONTROL, v);
    chk(v, 8'h28);
    @(posedge clk_i);
    #1 chk(rdata_o, 8'h00);
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v, 8'h08);
    rd(16'h0013, v);
    chk(v, 8'h00);
    chk(ss_gpio_o, 1'b1);
    chk(pins_owned_o, 1'b0);
    chk(tx_irq_o, 1'b0);
  endtask : t_reset

  // Master byte exchange, push-pull or wired-OR
  task automatic t_master(input logic wo);
    logic [7:0] v;
    int n;
    wr(spc_pkg::ADDR_STATUS, 8'h01);
    wr(spc_pkg::ADDR_CONTROL, {5'h15, wo, 2'h3});
    wr(spc_pkg::ADDR_DATA, 8'hA5);
    // Partner selected only after the clock pin settles, so the first drive is no edge
    wo_chk <= wo;
    sl_tx <= 8'h3C;
    sl_sel <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk(tx_irq_o, 1'b1);
    chk(pins_owned_o, 1'b1);
    chk(sck_oe_o, 1'b1);
    chk(mosi_oe_o, !wo);
    chk(ss_gpio_o, 1'b1);
    for (n = 0; n < 400 && rx_irq_o !== 1'b1; n++) @(posedge clk_i);
    #1 chk(rx_irq_o, 1'b1);
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v, 8'h89);
    rd(spc_pkg::ADDR_DATA, v);
    chk(v, 8'h3C);
    chk(sl_rx, 8'hA5);
    sl_sel <= 1'b0;
    wo_chk <= 1'b0;
  endtask : t_master

  // Disable in mid-byte, then re-enable
  task automatic t_abort;
    logic [7:0] v;
    wr(spc_pkg::ADDR_CONTROL, 8'h2A);
    sl_sel <= 1'b1;
    wr(spc_pkg::ADDR_DATA, 8'hF0);
    repeat (40) @(posedge clk_i);
    wr(spc_pkg::ADDR_CONTROL, 8'h28);
    repeat (3) @(posedge clk_i);
    #1 chk(pins_owned_o, 1'b0);
    chk(sck_oe_o, 1'b0);
    chk(ss_gpio_o, 1'b1);
    sl_sel <= 1'b0;
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v, 8'h09);
    wr(spc_pkg::ADDR_CONTROL, 8'h2A);
    repeat (200) @(posedge clk_i);
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v, 8'h09);
    wr(spc_pkg::ADDR_CONTROL, 8'h3A);
    repeat (3) @(posedge clk_i);
    #1 chk({sck_oe_o, sck_o}, 8'h03);
  endtask : t_abort

  // Slave exchange; phase one first runs a frame with select held high
  task automatic t_slave(input logic cpha, input logic [7:0] tx, input logic [7:0] ptx);
    logic [7:0] v;
    logic [7:0] pr;
    wr(spc_pkg::ADDR_CONTROL, {!cpha, 3'h0, cpha, 3'h2});
    wr(spc_pkg::ADDR_DATA, tx);
    repeat (4) @(posedge clk_i);
    #1 chk(ss_gpio_o, 1'b0);
    chk(miso_oe_o, 1'b0);
    chk(sck_oe_o, 1'b0);
    if (cpha) begin
      i_peer.xfer(8'hFF, 1'b1, 1'b0, 1'b0, pr);
      repeat (8) @(posedge clk_i);
      rd(spc_pkg::ADDR_STATUS, v);
      chk(v[7], 1'b0);
    end
    i_peer.xfer(ptx, cpha, 1'b1, cpha, pr);
    repeat (8) @(posedge clk_i);
    chk(pr, tx);
    chk(rx_irq_o, !cpha);
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v[7], 1'b1);
    rd(spc_pkg::ADDR_DATA, v);
    chk(v, ptx);
  endtask : t_slave

  // Select pulled low under an enabled master with fault detection
  task automatic t_fault;
    logic [7:0] v;
    wr(spc_pkg::ADDR_STATUS, 8'h45);
    wr(spc_pkg::ADDR_CONTROL, 8'hAA);
    repeat (4) @(posedge clk_i);
    #1 chk(ss_gpio_o, 1'b0);
    chk(err_irq_o, 1'b0);
    ss_force_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(spc_pkg::ADDR_STATUS, v);
    chk(v, 8'h5D);
    chk(err_irq_o, 1'b1);
    rd(spc_pkg::ADDR_CONTROL, v);
    chk(v, 8'hA8);
    ss_force_n <= 1'b1;
  endtask : t_fault

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_master(1'b0);
    t_master(1'b1);
    t_abort();
    t_slave(1'b0, 8'h5A, 8'hC3);
    t_slave(1'b1, 8'h96, 8'h69);
    t_fault();
    results();
  end
endmodule : tb_spc_spi
